// *** occr_pkg.sv ***
// Package: register map, fields, resets, timing and carriers
package occr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DELAY = 6'h0E;
  localparam logic [5:0] IDX_OUTCTL = 6'h10;
  localparam logic [5:0] IDX_CONFIG = 6'h11;
  localparam logic [5:0] IDX_CLKSRC = 6'h12;
  localparam logic [5:0] IDX_STATUS = 6'h18;
  localparam logic [5:0] IDX_MASK = 6'h19;
  // Output control fields
  localparam int OC_SEL3 = 5;
  localparam int OC_SEL2 = 4;
  localparam int OC_OD = 3;
  localparam int OC_GATE = 1;
  localparam int OC_LVL = 0;
  // General configuration fields
  localparam int CF_SU = 7;
  localparam int CF_SD = 6;
  localparam int CF_CKPD = 5;
  localparam int CF_EN1PD = 2;
  localparam int CF_TW = 1;
  localparam int CF_SS = 0;
  // Clock source fields
  localparam int CS_PLL = 6;
  localparam int CS_FREQ = 0;
  localparam logic [4:0] FREQ_MAX = 5'h17;
  // Delay fields
  localparam int DL_SD = 4;
  localparam int DL_SU = 0;
  // Reset values before the OTP load
  localparam logic [7:0] RST_OUTCTL = 8'h0A;
  localparam logic [7:0] RST_CONFIG = 8'h3C;
  localparam logic [7:0] RST_CLKSRC = 8'h02;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [1:0] RST_MASK = 2'h3;
  // Status bits
  localparam int ST_ARRIVE = 0;
  localparam int ST_LOSS = 1;
  // Timing
  localparam int CLK_FREQ_MHZ = 200;
  localparam int STEP_FINE_US = 500;
  localparam int STEP_COARSE_US = 1000;
  localparam int FINE_CYC = STEP_FINE_US * CLK_FREQ_MHZ;
  localparam int COARSE_CYC = STEP_COARSE_US * CLK_FREQ_MHZ;
  // OTP default image
  typedef struct packed {
    logic [7:0] outctl;
    logic [7:0] config_b;
    logic [7:0] clksrc;
    logic [7:0] delay;
  } occr_otp_t;
  // Analog and clocking controls
  typedef struct packed {
    logic       ss_on;
    logic       therm_hi;
    logic       clk_pd;
    logic [2:0] en_pd;
    logic       pll_on;
    logic       use_ext;
    logic [4:0] freq;
    logic       freq_ok;
    logic       second_gpo;
    logic       external_clock_input_func;
  } occr_ctl_t;
endpackage

// *** occr_top.sv ***
// Output clock configuration register bank with Avalon-MM slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module occr_top
#(
  parameter int FINE_CYCLES   = occr_pkg::FINE_CYC,
  parameter int COARSE_CYCLES = occr_pkg::COARSE_CYC
)
(
  // Clock and reset
  input  wire logic               CLK_I,
  input  wire logic               RSTN_I,
  // Avalon-MM slave
  input  wire logic [7:0]         ADDRESS_I,
  input  wire logic               READ_I,
  input  wire logic               WRITE_I,
  input  wire logic [3:0]         BYTEENABLE_I,
  input  wire logic [31:0]        WRITEDATA_I,
  output logic      [31:0]        READDATA_O,
  output logic                    WAITREQUEST_O,
  // OTP defaults
  input  wire occr_pkg::occr_otp_t OTP_I,
  // Pins and detector
  input  wire logic [2:0]         EN_PINS_I,
  input  wire logic               EXT_CLK_OK_I,
  // Third output pin
  output logic                    THIRD_OUT_O,
  output logic                    THIRD_OE_O,
  // Controls and interrupt
  output occr_pkg::occr_ctl_t     CTL_O,
  output logic                    IRQ_O
);
  import occr_pkg::*;

  localparam int SW = 18;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_ACK  = 3'b100
  } occr_state_t;

  typedef struct packed {
    occr_state_t st;
    logic [7:0]  outctl;
    logic [7:0]  cfg;
    logic [7:0]  clksrc;
    logic [7:0]  dly;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic        wait_r;
    logic [31:0] rdata;
    logic [2:0]  en_s1;
    logic [2:0]  en_s2;
    logic        ck_s1;
    logic        ck_s2;
    logic        ck_prev;
    logic        dly_out;
    logic [SW-1:0] tick;
    logic [3:0]  steps;
    logic        pin_out;
    logic        pin_oe;
    occr_ctl_t   ctl;
    logic        irq;
  } occr_regs_t;

  occr_regs_t r_reg;
  occr_regs_t r_next;

  // Enable-pin gating of the level bit
  function automatic logic occr_gate(
    input logic [1:0] code,
    input logic [2:0] en
  );
    logic g;
    g = 1'b1;
    unique case (code)
      2'h0: g = 1'b1;
      2'h1: g = en[0];
      2'h2: g = en[1];
      2'h3: g = en[2];
    endcase
    return g;
  endfunction

  // Last tick of a step (length in cycles minus one) for a range select bit
  function automatic logic [SW-1:0] occr_step(input logic coarse);
    logic [SW-1:0] s;
    s = coarse ? SW'(COARSE_CYCLES - 1) : SW'(FINE_CYCLES - 1);
    return s;
  endfunction

  // Read mux over the mapped words; unmapped reads give zero
  function automatic logic [7:0] occr_rd(
    input logic [5:0] idx,
    input occr_regs_t r
  );
    logic [7:0] d;
    d = 8'h00;
    if (idx == IDX_OUTCTL)
    begin
      d = r.outctl;
    end
    else if (idx == IDX_CONFIG)
    begin
      d = r.cfg;
    end
    else if (idx == IDX_CLKSRC)
    begin
      d = r.clksrc;
    end
    else if (idx == IDX_DELAY)
    begin
      d = r.dly;
    end
    else if (idx == IDX_STATUS)
    begin
      d = {6'h00, r.sts};
    end
    else if (idx == IDX_MASK)
    begin
      d = {6'h00, r.msk};
    end
    return d;
  endfunction

  // Next-state logic for bus, events, delay and pins
  always_comb
  begin
    logic [5:0]    idx;
    logic          ctrl;
    logic          rising;
    logic [3:0]    code;
    logic [SW-1:0] last;
    logic          pll_on;
    idx = ADDRESS_I[7:2];
    ctrl = 1'b0;
    rising = 1'b0;
    code = 4'h0;
    last = '0;
    pll_on = 1'b0;
    r_next = r_reg;

    // Two-stage synchronisers; stage one feeds stage two only
    r_next.en_s1 = EN_PINS_I;
    r_next.en_s2 = r_reg.en_s1;
    r_next.ck_s1 = EXT_CLK_OK_I;
    r_next.ck_s2 = r_reg.ck_s1;
    r_next.ck_prev = r_reg.ck_s2;

    // Bus state machine; one wait cycle per access
    unique case (r_reg.st)
      ST_LOAD:
      begin
        // Defaults loaded once after reset release
        r_next.outctl = OTP_I.outctl;
        r_next.cfg = OTP_I.config_b;
        r_next.clksrc = OTP_I.clksrc;
        r_next.dly = OTP_I.delay;
        r_next.st = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (READ_I || WRITE_I)
        begin
          r_next.st = ST_ACK;
          r_next.wait_r = 1'b0;
          if (READ_I)
          begin
            r_next.rdata = {24'h000000, occr_rd(idx, r_reg)};
          end
        end
      end
      ST_ACK:
      begin
        r_next.st = ST_IDLE;
        r_next.wait_r = 1'b1;
        if (WRITE_I && BYTEENABLE_I[0])
        begin
          if (idx == IDX_OUTCTL)
          begin
            r_next.outctl = WRITEDATA_I[7:0];
          end
          if (idx == IDX_CONFIG)
          begin
            r_next.cfg = WRITEDATA_I[7:0];
          end
          if (idx == IDX_CLKSRC)
          begin
            r_next.clksrc = WRITEDATA_I[7:0];
          end
          if (idx == IDX_DELAY)
          begin
            r_next.dly = WRITEDATA_I[7:0];
          end
          if (idx == IDX_MASK)
          begin
            r_next.msk = WRITEDATA_I[1:0];
          end
        end
        // Read clears only the bits it returned, so an event
        // that lands while the read is pending is not lost
        if (READ_I && idx == IDX_STATUS)
        begin
          r_next.sts = r_reg.sts & ~r_reg.rdata[1:0];
        end
      end
    endcase

    // Clock arrival and loss events, only while the PLL runs
    pll_on = r_reg.clksrc[CS_PLL];
    if (pll_on && r_reg.ck_s2 && !r_reg.ck_prev)
    begin
      r_next.sts[ST_ARRIVE] = 1'b1;
    end
    if (pll_on && !r_reg.ck_s2 && r_reg.ck_prev)
    begin
      r_next.sts[ST_LOSS] = 1'b1;
    end
    r_next.irq = |(r_next.sts & r_next.msk);

    // Gated control signal of the third output
    ctrl = r_reg.outctl[OC_LVL] &
           occr_gate(r_reg.outctl[OC_GATE +: 2], r_reg.en_s2);

    // Rise uses startup range, fall uses shutdown range
    rising = ctrl;
    code = rising ? r_reg.dly[DL_SU +: 4]
                  : r_reg.dly[DL_SD +: 4];
    last = rising ? occr_step(r_reg.cfg[CF_SU])
                  : occr_step(r_reg.cfg[CF_SD]);

    // A change back before expiry restarts the count
    if (ctrl == r_reg.dly_out)
    begin
      r_next.tick = '0;
      r_next.steps = 4'h0;
    end
    else if (r_reg.steps == code)
    begin
      r_next.dly_out = ctrl;
      r_next.tick = '0;
      r_next.steps = 4'h0;
    end
    else if (r_reg.tick == last)
    begin
      r_next.tick = '0;
      r_next.steps = r_reg.steps + 4'h1;
    end
    else
    begin
      r_next.tick = r_reg.tick + SW'(1);
    end

    // Pin drive only while the shared pin is an output
    if (r_reg.outctl[OC_SEL3])
    begin
      if (r_reg.outctl[OC_OD])
      begin
        // Open drain: drive low only, release for high
        r_next.pin_out = 1'b0;
        r_next.pin_oe = ~r_reg.dly_out;
      end
      else
      begin
        r_next.pin_out = r_reg.dly_out;
        r_next.pin_oe = 1'b1;
      end
    end
    else
    begin
      r_next.pin_out = 1'b0;
      r_next.pin_oe = 1'b0;
    end

    // Analog and clocking controls
    r_next.ctl.ss_on = r_reg.cfg[CF_SS];
    r_next.ctl.therm_hi = r_reg.cfg[CF_TW];
    r_next.ctl.clk_pd = r_reg.cfg[CF_CKPD];
    r_next.ctl.en_pd = r_reg.cfg[CF_EN1PD +: 3];
    r_next.ctl.pll_on = pll_on;
    // External clock only with PLL on and a clock present
    r_next.ctl.use_ext = pll_on & r_reg.ck_s2;
    r_next.ctl.freq = r_reg.clksrc[CS_FREQ +: 5];
    // Reserved codes are flagged, not corrected
    r_next.ctl.freq_ok =
      (r_reg.clksrc[CS_FREQ +: 5] <= FREQ_MAX);
    r_next.ctl.second_gpo = r_reg.outctl[OC_SEL2];
    r_next.ctl.external_clock_input_func = ~r_reg.outctl[OC_SEL3];
  end

  // State register; constants only under reset
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      r_reg <= '0;
      r_reg.st <= ST_LOAD;
      r_reg.outctl <= RST_OUTCTL;
      r_reg.cfg <= RST_CONFIG;
      r_reg.clksrc <= RST_CLKSRC;
      r_reg.dly <= RST_DELAY;
      r_reg.msk <= RST_MASK;
      r_reg.wait_r <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign READDATA_O = r_reg.rdata;
  assign WAITREQUEST_O = r_reg.wait_r;
  assign THIRD_OUT_O = r_reg.pin_out;
  assign THIRD_OE_O = r_reg.pin_oe;
  assign CTL_O = r_reg.ctl;
  assign IRQ_O = r_reg.irq;
endmodule

// *** occr_assertions.sv ***
// Port checker of the output clock config register bank
`timescale 1ns/1ps
module occr_chk
(
  // Clock and reset
  input wire logic                CLK_I,
  input wire logic                RSTN_I,
  // Register bus
  input wire logic [7:0]          ADDRESS_I,
  input wire logic                WRITE_I,
  input wire logic [3:0]          BYTEENABLE_I,
  input wire logic [31:0]         WRITEDATA_I,
  input wire logic                WAITREQUEST_O,
  // Pins, controls and interrupt
  input wire logic                EXT_CLK_OK_I,
  input wire logic                THIRD_OUT_O,
  input wire logic                THIRD_OE_O,
  input wire occr_pkg::occr_ctl_t CTL_O,
  input wire logic                IRQ_O
);
  import occr_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // A write lands only at the edge that sees waitrequest low
  logic       wr_ok;
  logic [5:0] idx;
  logic [7:0] wd;
  assign wr_ok = WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0];
  assign idx = ADDRESS_I[7:2];
  assign wd = WRITEDATA_I[7:0];
  // Controls are registered from the registers: two edges after a write
  sel_input_a:
    assert property (CTL_O.external_clock_input_func [*3] |-> !THIRD_OE_O)
    else $error("pin driven in clock input mode");
  pin_func_a:
    assert property (wr_ok && idx == IDX_OUTCTL |-> ##2
      {CTL_O.second_gpo, CTL_O.external_clock_input_func} == $past({wd[4], !wd[5]}, 2))
    else $error("pin function select wrong");
  od_drive_a:
    assert property (THIRD_OUT_O |-> THIRD_OE_O)
    else $error("high level without drive");
  cfg_ctl_a:
    assert property (wr_ok && idx == IDX_CONFIG |-> ##2
      {CTL_O.clk_pd, CTL_O.en_pd, CTL_O.ss_on} == $past({wd[5:2], wd[0]}, 2))
    else $error("pull-down or spread control wrong");
  int_osc_a:
    assert property (!CTL_O.pll_on |-> !CTL_O.use_ext)
    else $error("external clock used with PLL off");
  ext_use_a:
    assert property ((CTL_O.pll_on && EXT_CLK_OK_I) [*6] |-> CTL_O.use_ext)
    else $error("external clock not used");
  clk_evt_a:
    assert property ($changed(EXT_CLK_OK_I) && CTL_O.pll_on |-> ##[2:8] IRQ_O)
    else $error("no interrupt on clock change");
  freq_code_a:
    assert property (wr_ok && idx == IDX_CLKSRC |-> ##2 {CTL_O.freq,
      CTL_O.freq_ok} == $past({wd[4:0], wd[4:0] <= FREQ_MAX}, 2))
    else $error("frequency code wrong");
  // Main scenarios reached
  cover property ($rose(IRQ_O));
  cover property ($rose(THIRD_OUT_O) && THIRD_OE_O);
  cover property (wr_ok && idx == IDX_CLKSRC);
endmodule
bind occr_top occr_chk i_occr_chk (.CLK_I, .RSTN_I, .ADDRESS_I, .WRITE_I,
  .BYTEENABLE_I, .WRITEDATA_I, .WAITREQUEST_O, .EXT_CLK_OK_I, .THIRD_OUT_O,
  .THIRD_OE_O, .CTL_O, .IRQ_O);

// *** occr_top_tb.sv ***
// Self-checking bench of the output clock config register bank
`timescale 1ns/1ps
module occr_top_tb;
  import occr_pkg::*;
  // Short steps keep the delay tests brief
  localparam int FINE = 4;
  localparam int COARSE = 8;
  // Stimulus and observed outputs
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [2:0]  en = 3'h0;
  logic        ck_ok = 1'b0;
  logic [3:0]  be = 4'hF;
  occr_otp_t   otp = 32'h0;
  logic [31:0] rdat;
  logic        wt, pin, oe, irq;
  occr_ctl_t   ctl;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  occr_top #(.FINE_CYCLES(FINE), .COARSE_CYCLES(COARSE)) i_occr_top (
    .CLK_I(clk), .RSTN_I(rst_n), .ADDRESS_I(adr), .READ_I(rd), .WRITE_I(wr),
    .BYTEENABLE_I(be), .WRITEDATA_I(wd), .READDATA_O(rdat),
    .WAITREQUEST_O(wt), .OTP_I(otp), .EN_PINS_I(en), .EXT_CLK_OK_I(ck_ok),
    .THIRD_OUT_O(pin), .THIRD_OE_O(oe), .CTL_O(ctl), .IRQ_O(irq));
  // Clock, and a hang guard well above the expected run
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d,
                     output logic [31:0] q);
    rd <= !w;
    wr <= w;
    adr <= {i, 2'h0};
    wd <= {24'h0, d};
    @(posedge clk);
    while (wt !== 1'b0)
      @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr8(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rchk(input logic [5:0] i, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  // Cycles until the pin shows the level, capped so a stuck pin ends
  task automatic span(input logic lv, output int n);
    n = 0;
    while (pin !== lv && n < 100)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // Level bit, gated by the enable pin that the code picks
  function automatic logic exp_out(input logic [7:0] c, input logic [2:0] e);
    return c[0] && (c[2:1] == 2'h0 || e[c[2:1] - 2'h1]);
  endfunction
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    logic [7:0] v;
    logic [7:0] c;
    logic [4:0] f;
    logic       e;
    int         n;
    void'($urandom(10692));
    otp <= $urandom;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Defaults from the OTP image; an unmapped word reads zero
    rchk(IDX_OUTCTL, otp.outctl);
    rchk(IDX_CONFIG, otp.config_b);
    rchk(IDX_CLKSRC, otp.clksrc);
    rchk(IDX_DELAY, otp.delay);
    rchk(6'h20, 8'h00);
    // A write with byte lane 0 disabled is dropped
    be <= 4'h0;
    wr8(IDX_DELAY, 8'h5A);
    be <= 4'hF;
    rchk(IDX_DELAY, otp.delay);
    $display("test 1 done");
    // Random pin modes, drive types, gating codes and enable pins
    wr8(IDX_DELAY, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      v = 8'($urandom);
      e = exp_out(v, v[7:5]);
      en <= v[7:5];
      c = 8'($urandom);
      wr8(IDX_CONFIG, c);
      wr8(IDX_OUTCTL, v);
      repeat (8) @(posedge clk);
      chk({ctl.ss_on, ctl.therm_hi, ctl.clk_pd, ctl.en_pd},
          {c[0], c[1], c[5:2]});
      chk({ctl.second_gpo, ctl.external_clock_input_func}, {v[4], !v[5]});
      if (v[5])
        chk({pin, oe}, v[3] ? {1'b0, !e} : {e, 1'b1});
      else
        chk(oe, 1'b0);
    end
    $display("test 2 done");
    // Startup on fine steps, shutdown on coarse steps
    wr8(IDX_CONFIG, 8'h40);
    wr8(IDX_DELAY, 8'h23);
    wr8(IDX_OUTCTL, 8'h20);
    repeat (40) @(posedge clk);
    wr8(IDX_OUTCTL, 8'h21);
    span(1'b1, n);
    chk(n >= 3 * FINE && n <= 3 * FINE + 8, 1);
    wr8(IDX_OUTCTL, 8'h20);
    span(1'b0, n);
    chk(n >= 2 * COARSE && n <= 2 * COARSE + 8, 1);
    $display("test 3 done");
    // PLL off before any frequency change; upper three bits kept zero
    wr8(IDX_CLKSRC, otp.clksrc & 8'h1F);
    for (int i = 0; i < 4; i++)
    begin
      f = (i == 0) ? 5'h18 : 5'($urandom);
      wr8(IDX_CLKSRC, {3'h0, f});
      rchk(IDX_CLKSRC, {3'h0, f});
      chk({ctl.freq, ctl.freq_ok}, {f, f <= FREQ_MAX});
    end
    wr8(IDX_CLKSRC, {3'h2, f});
    ck_ok <= 1'b1;
    repeat (10) @(posedge clk);
    chk({irq, ctl.use_ext}, 2'h3);
    rchk(IDX_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    ck_ok <= 1'b0;
    repeat (10) @(posedge clk);
    wr8(IDX_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk({irq, ctl.use_ext}, 2'h0);
    wr8(IDX_MASK, 8'h03);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rchk(IDX_STATUS, 8'h02);
    wr8(IDX_CLKSRC, {3'h0, f});
    ck_ok <= 1'b1;
    repeat (10) @(posedge clk);
    chk({irq, ctl.use_ext, ctl.pll_on}, 3'h0);
    $display("test 4 done");
    // Reset in mid-run reloads the OTP image with the clock present
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(IDX_CLKSRC, otp.clksrc);
    chk({ctl.pll_on, ctl.use_ext},
        {otp.clksrc[CS_PLL], otp.clksrc[CS_PLL]});
    $display("test 5 done");
    end_of_test;
  end
endmodule
